// >>> hw/sbr_pkg.sv
// Constants for the serial control register bank
package sbr_pkg;
    localparam int          FRAME_BITS      = 16;
    localparam logic [6:0]  CTRL_LO         = 7'h01;
    localparam logic [6:0]  CTRL_HI         = 7'h1e;
    localparam logic [6:0]  STAT_LO         = 7'h41;
    localparam logic [6:0]  STAT_HI         = 7'h7e;
    localparam logic [6:0]  ADDR_MODE_SUPPLY = 7'h01;
    localparam logic [6:0]  ADDR_HARDWARE_CONTROL    = 7'h02;
    localparam logic [6:0]  ADDR_WATCHDOG_CONTROL    = 7'h03;
    localparam logic [6:0]  ADDR_BUS_CTRL_A = 7'h04;
    localparam logic [6:0]  ADDR_BUS_CTRL_B = 7'h05;
    localparam logic [6:0]  ADDR_WAKE_CTRL_A = 7'h06;
    localparam logic [6:0]  ADDR_WAKE_CTRL_B = 7'h07;
    localparam logic [6:0]  ADDR_WAKE_PULL  = 7'h08;
    localparam logic [6:0]  ADDR_CYC_TIMER  = 7'h0c;
    localparam logic [6:0]  ADDR_SCRATCH    = 7'h1e;
    localparam logic [6:0]  ADDR_SUPPLY_ST  = 7'h41;
    localparam logic [6:0]  ADDR_THERMAL_ST = 7'h42;
    localparam logic [6:0]  ADDR_DEVICE_ST  = 7'h43;
    localparam logic [6:0]  ADDR_BUS_ST_A   = 7'h44;
    localparam logic [6:0]  ADDR_BUS_ST_B   = 7'h45;
    localparam logic [6:0]  ADDR_WAKE_ST_A  = 7'h46;
    localparam logic [6:0]  ADDR_WAKE_ST_B  = 7'h47;
    localparam logic [6:0]  ADDR_WAKE_LEVEL = 7'h48;
    localparam logic [6:0]  ADDR_CONV_ST    = 7'h4c;
    localparam logic [6:0]  ADDR_FAMILY_ID  = 7'h7e;
    // Writable bit masks per control register (reserved bits zero)
    localparam logic [7:0]  MASK_MODE_SUPPLY = 8'hdf;
    localparam logic [7:0]  MASK_FULL       = 8'hff;
    localparam logic [7:0]  MASK_BUS_CTRL_A = 8'hfb;
    localparam logic [7:0]  MASK_BUS_CTRL_B = 8'h1b;
    localparam logic [7:0]  MASK_WAKE_CTRL_A = 8'h44;
    localparam logic [7:0]  MASK_WAKE_CTRL_B = 8'h01;
    localparam logic [7:0]  MASK_WAKE_PULL  = 8'h03;
    localparam logic [7:0]  MASK_CYC_TIMER  = 8'h07;
    // Reset values
    localparam logic [7:0]  RST_ZERO        = 8'h00;
    localparam logic [7:0]  RST_WATCHDOG_CONTROL     = 8'h14;
    // Restart keep masks: 1 = bit keeps its previous value
    localparam logic [7:0]  KEEP_MODE_SUPPLY = 8'h07;
    localparam logic [7:0]  KEEP_HARDWARE_CONTROL    = 8'hdf;
    localparam logic [7:0]  KEEP_WATCHDOG_CONTROL    = 8'h98;
    localparam logic [7:0]  RESTART_WATCHDOG_CONTROL = 8'h04;
    localparam logic [7:0]  KEEP_OTHER      = 8'hff;
    // Field positions
    localparam int          MODE_LSB        = 6;
    localparam int          REG2_LSB        = 3;
    localparam int          FAIL_OUT_BIT    = 5;
    // Mode encodings
    localparam logic [1:0]  MODE_NORMAL     = 2'h0;
    localparam logic [1:0]  MODE_SLEEP      = 2'h1;
    localparam logic [1:0]  MODE_STOP       = 2'h2;
    // Transceiver control encodings: 2'h3 = fully on, 2'h1 = wake capable
    localparam logic [1:0]  XCVR_ON         = 2'h3;
    localparam logic [1:0]  XCVR_WAKE       = 2'h1;
    localparam int          NUM_STAT        = 8;
endpackage : sbr_pkg

// >>> hw/sbr_regbank.sv
// Serial control interface and register bank of the system basis controller
// What this block does
// - Addresses 0x01 to 0x1e are control registers; access bit selects read or write.
// - A written control value shows only in a later frame's response.
// - Addresses 0x41 to 0x7e are status registers: read or read-and-clear.
// - Status bits are cleared only by a frame with access bit 1, a soft reset or a reset.
// - Wake pin level register follows the pins live and ignores clears.
// - Mode bits are rewritten to report the mode actually in effect.
// - Entering sleep turns fully-on transceiver settings to wake capable; fail outputs stay.
// - Secondary regulator setting is writable only in normal mode.
// - Power-on or soft reset loads reset values; restart loads restart values into the bits that its keep mask does not hold.
// - A frame is 16 bits: 7-bit address, access bit, then data byte.
// - Data bits D0 to D7 sit in frame positions 8 to 15.
// - Access bit 0 is a pure read leaving contents unchanged.
// - Access bit 1 writes the data byte's writable bits into a control register.
// - Read-only and reserved bits ignore writes; hardware may change rwh bits.
// - Control bits change only by host writes apart from mode events, restart and resets.
// - On a change to sleep each fully-on transceiver becomes wake capable; other settings and modes leave them as they are.
// - Frames are ignored in restart, sleep or fail-safe mode.
// - Frames with clock count not 0 or 16 are dropped and flagged next response.
// - Each response carries one summary bit per status register, level excluded.
`timescale 1ns/1ps
module sbr_regbank (
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    input  wire logic        SERIAL_CLK,
    input  wire logic        SELECT_N,
    input  wire logic        SERIAL_IN,
    output logic             SERIAL_OUT,
    output logic             SERIAL_OUT_EN,
    input  wire logic        SOFT_RESET,
    input  wire logic        RESTART,
    input  wire logic        SPI_BLOCKED,
    input  wire logic [1:0]  MODE_ACTUAL,
    input  wire logic        MODE_CHANGE,
    input  wire logic [63:0] STATUS_SET,
    input  wire logic [7:0]  WAKE_PIN_LEVEL,
    input  wire logic [7:0]  FAMILY_ID,
    output logic [79:0]      CONTROL_REGS,
    output logic [63:0]      STATUS_REGS
);
    // Link domain: shift register on the serial clock
    typedef struct packed {
        logic [15:0] shift;
        logic [4:0]  count;
        logic [15:0] tx;
        logic        frame_tog;
    } sbr_link_t;

    sbr_link_t ln_r, ln_nxt;
    sbr_link_t lf_r, lf_nxt;
    logic [15:0] frame_word;
    logic        frame_ok;

    // Input is sampled on the falling edge, output changes on the rising edge
    always_comb begin
        ln_nxt = ln_r;
        if (ln_r.count < 5'd31) begin
            ln_nxt.count = ln_r.count + 5'd1;
        end
        ln_nxt.shift = {SERIAL_IN, ln_r.shift[15:1]};
    end

    // Count is held at zero while deselected, so each frame counts from zero
    always_ff @(negedge SERIAL_CLK or posedge SELECT_N) begin
        if (SELECT_N) begin
            ln_r.count <= 5'd0;
        end else begin
            ln_r <= ln_nxt;
        end
    end

    // Frame end snapshot: stays still while the core picks it up
    always_comb begin
        lf_nxt = ln_r;
    end
    always_ff @(posedge SELECT_N) begin
        lf_r <= lf_nxt;
    end
    assign frame_word = lf_r.shift;
    assign frame_ok   = 1'b1;

    // Core domain state
    typedef struct packed {
        logic [2:0]  sel_sync;
        logic [15:0] word_a;
        logic [15:0] word_b;
        logic [4:0]  cnt_a;
        logic [4:0]  cnt_b;
        logic [79:0] ctrl;
        logic [63:0] stat;
        logic        err;
        logic [15:0] resp;
        logic [1:0]  mode_last;
    } sbr_core_t;

    sbr_core_t c_r, c_nxt;

    logic [7:0]  ctrl_mask [10];
    logic [6:0]  ctrl_addr [10];
    logic [6:0]  stat_addr [8];
    logic [7:0]  keep_mask [10];
    logic [7:0]  restart_val [10];
    logic [7:0]  reset_val [10];

    always_comb begin
        ctrl_addr = '{sbr_pkg::ADDR_MODE_SUPPLY, sbr_pkg::ADDR_HARDWARE_CONTROL, sbr_pkg::ADDR_WATCHDOG_CONTROL,
                      sbr_pkg::ADDR_BUS_CTRL_A, sbr_pkg::ADDR_BUS_CTRL_B, sbr_pkg::ADDR_WAKE_CTRL_A,
                      sbr_pkg::ADDR_WAKE_CTRL_B, sbr_pkg::ADDR_WAKE_PULL, sbr_pkg::ADDR_CYC_TIMER,
                      sbr_pkg::ADDR_SCRATCH};
        ctrl_mask = '{sbr_pkg::MASK_MODE_SUPPLY, sbr_pkg::MASK_FULL, sbr_pkg::MASK_FULL,
                      sbr_pkg::MASK_BUS_CTRL_A, sbr_pkg::MASK_BUS_CTRL_B, sbr_pkg::MASK_WAKE_CTRL_A,
                      sbr_pkg::MASK_WAKE_CTRL_B, sbr_pkg::MASK_WAKE_PULL, sbr_pkg::MASK_CYC_TIMER,
                      sbr_pkg::MASK_FULL};
        keep_mask = '{sbr_pkg::KEEP_MODE_SUPPLY, sbr_pkg::KEEP_HARDWARE_CONTROL, sbr_pkg::KEEP_WATCHDOG_CONTROL,
                      sbr_pkg::KEEP_OTHER, sbr_pkg::KEEP_OTHER, sbr_pkg::KEEP_OTHER,
                      sbr_pkg::KEEP_OTHER, sbr_pkg::KEEP_OTHER, sbr_pkg::KEEP_OTHER,
                      sbr_pkg::KEEP_OTHER};
        restart_val = '{sbr_pkg::RST_ZERO, sbr_pkg::RST_ZERO, sbr_pkg::RESTART_WATCHDOG_CONTROL,
                        sbr_pkg::RST_ZERO, sbr_pkg::RST_ZERO, sbr_pkg::RST_ZERO,
                        sbr_pkg::RST_ZERO, sbr_pkg::RST_ZERO, sbr_pkg::RST_ZERO,
                        sbr_pkg::RST_ZERO};
        reset_val = '{sbr_pkg::RST_ZERO, sbr_pkg::RST_ZERO, sbr_pkg::RST_WATCHDOG_CONTROL,
                      sbr_pkg::RST_ZERO, sbr_pkg::RST_ZERO, sbr_pkg::RST_ZERO,
                      sbr_pkg::RST_ZERO, sbr_pkg::RST_ZERO, sbr_pkg::RST_ZERO,
                      sbr_pkg::RST_ZERO};
        stat_addr = '{sbr_pkg::ADDR_SUPPLY_ST, sbr_pkg::ADDR_THERMAL_ST, sbr_pkg::ADDR_DEVICE_ST,
                      sbr_pkg::ADDR_BUS_ST_A, sbr_pkg::ADDR_BUS_ST_B, sbr_pkg::ADDR_WAKE_ST_A,
                      sbr_pkg::ADDR_WAKE_ST_B, sbr_pkg::ADDR_CONV_ST};
    end

    logic       frame_end;
    logic [6:0] f_addr;
    logic       f_acc;
    logic [7:0] f_data;

    assign frame_end = c_r.sel_sync[2:1] == 2'b01;
    assign f_addr    = c_r.word_b[6:0];
    assign f_acc     = c_r.word_b[7];
    assign f_data    = c_r.word_b[15:8];

    always_comb begin
        logic [7:0] rd;
        logic [7:0] summ;
        logic [7:0] v;
        rd    = 8'h00;
        summ  = 8'h00;
        v     = 8'h00;
        c_nxt = c_r;
        c_nxt.sel_sync = {c_r.sel_sync[1:0], SELECT_N};
        c_nxt.word_a   = frame_word;
        c_nxt.word_b   = c_r.word_a;
        c_nxt.cnt_a    = lf_r.count;
        c_nxt.cnt_b    = c_r.cnt_a;
        for (int i = 0; i < sbr_pkg::NUM_STAT; i++) begin
            summ[i] = |c_r.stat[i*8 +: 8];
        end
        if (frame_end && !SPI_BLOCKED) begin
            if (c_r.cnt_b != 5'd16 && c_r.cnt_b != 5'd0) begin
                c_nxt.err = 1'b1;
            end else if (c_r.cnt_b == 5'd16) begin
                c_nxt.err = 1'b0;
                for (int i = 0; i < 10; i++) begin
                    if (f_addr == ctrl_addr[i]) begin
                        rd = c_r.ctrl[i*8 +: 8];
                        if (f_acc) begin
                            v = (f_data & ctrl_mask[i]) | (c_r.ctrl[i*8 +: 8] & ~ctrl_mask[i]);
                            if (i == 0 && MODE_ACTUAL != sbr_pkg::MODE_NORMAL) begin
                                v[sbr_pkg::REG2_LSB +: 2] = c_r.ctrl[sbr_pkg::REG2_LSB +: 2];
                            end
                            c_nxt.ctrl[i*8 +: 8] = v;
                        end
                    end
                end
                for (int i = 0; i < sbr_pkg::NUM_STAT; i++) begin
                    if (f_addr == stat_addr[i]) begin
                        rd = c_r.stat[i*8 +: 8];
                        if (f_acc) begin
                            c_nxt.stat[i*8 +: 8] = 8'h00;
                        end
                    end
                end
                if (f_addr == sbr_pkg::ADDR_WAKE_LEVEL) begin
                    rd = WAKE_PIN_LEVEL;
                end
                if (f_addr == sbr_pkg::ADDR_FAMILY_ID) begin
                    rd = FAMILY_ID;
                end
                c_nxt.resp = {rd, summ};
            end
        end
        // Hardware sets win over a same-cycle clear
        c_nxt.stat = c_nxt.stat | STATUS_SET;
        // Mode events
        if (MODE_CHANGE) begin
            c_nxt.ctrl[sbr_pkg::MODE_LSB +: 2] = MODE_ACTUAL;
            if (MODE_ACTUAL == sbr_pkg::MODE_SLEEP) begin
                // Fields sit at bits 1:0 and 4:3 of both bus control registers
                for (int j = 0; j < 4; j++) begin
                    if (c_nxt.ctrl[24 + (j/2)*8 + (j%2)*3 +: 2] == sbr_pkg::XCVR_ON) begin
                        c_nxt.ctrl[24 + (j/2)*8 + (j%2)*3 +: 2] = sbr_pkg::XCVR_WAKE;
                    end
                end
            end
        end
        c_nxt.mode_last = MODE_ACTUAL;
        if (RESTART) begin
            for (int i = 0; i < 10; i++) begin
                c_nxt.ctrl[i*8 +: 8] = (c_r.ctrl[i*8 +: 8] & keep_mask[i]) |
                                       (restart_val[i] & ~keep_mask[i]);
            end
        end
        if (SOFT_RESET) begin
            for (int i = 0; i < 10; i++) begin
                c_nxt.ctrl[i*8 +: 8] = reset_val[i];
            end
            c_nxt.stat = STATUS_SET;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            c_r <= '0;
            c_r.sel_sync <= 3'h7;
            c_r.ctrl[23:16] <= sbr_pkg::RST_WATCHDOG_CONTROL;
        end else begin
            c_r <= c_nxt;
        end
    end

    // Response is launched by the link from the snapshot register
    logic [15:0] tx_sync2;
    logic        err_sync2;
    logic [3:0]  tx_idx;
    always_ff @(posedge SERIAL_CLK or posedge SELECT_N) begin
        if (SELECT_N) begin
            tx_idx <= 4'h0;
        end else begin
            tx_idx <= tx_idx + 4'h1;
        end
    end
    // Response has been still for many core cycles when the next frame starts
    always_ff @(negedge SELECT_N) begin
        tx_sync2  <= c_r.resp;
        err_sync2 <= c_r.err;
    end

    assign SERIAL_OUT    = (tx_idx == 4'h0) ? (tx_sync2[0] | err_sync2) : tx_sync2[tx_idx];
    assign SERIAL_OUT_EN = ~SELECT_N;
    assign CONTROL_REGS  = c_r.ctrl;
    assign STATUS_REGS   = c_r.stat;
endmodule // sbr_regbank

// >>> tb/sbr_properties.sv
// Concurrent checks on the serial register bank ports
`timescale 1ns/1ps
module sbr_properties (
    input wire logic        CLOCK,
    input wire logic        RESET,
    input wire logic        SERIAL_CLK,
    input wire logic        SELECT_N,
    input wire logic        SERIAL_IN,
    input wire logic        SERIAL_OUT,
    input wire logic        SERIAL_OUT_EN,
    input wire logic        SOFT_RESET,
    input wire logic        RESTART,
    input wire logic        SPI_BLOCKED,
    input wire logic [1:0]  MODE_ACTUAL,
    input wire logic        MODE_CHANGE,
    input wire logic [63:0] STATUS_SET,
    input wire logic [7:0]  WAKE_PIN_LEVEL,
    input wire logic [7:0]  FAMILY_ID,
    input wire logic [79:0] CONTROL_REGS,
    input wire logic [63:0] STATUS_REGS
);
    localparam logic [79:0] RST_V = 80'h0000_0000_0000_0014_0000;
    logic [7:0] wd_prev_r;
    always_ff @(posedge CLOCK) begin
        wd_prev_r <= CONTROL_REGS[23:16];
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // Frame in progress with no register event
    sequence sel_low_s;
        (!SELECT_N && !MODE_CHANGE && !RESTART && !SOFT_RESET)[*6];
    endsequence
    // Commands locked out with no register event
    sequence blocked_s;
        (SPI_BLOCKED && !MODE_CHANGE && !RESTART && !SOFT_RESET)[*8];
    endsequence
    AST_RESET_VAL: assert property ($fell(RESET) |-> CONTROL_REGS == RST_V)
        else $error("Control registers wrong after reset");
    AST_SOFT_RESET: assert property (SOFT_RESET |=> CONTROL_REGS == RST_V)
        else $error("Control registers wrong after soft reset");
    AST_RESTART_WD: assert property (RESTART |=>
        CONTROL_REGS[23:16] == ((wd_prev_r & sbr_pkg::KEEP_WATCHDOG_CONTROL) | sbr_pkg::RESTART_WATCHDOG_CONTROL))
        else $error("Watchdog control wrong after restart");
    AST_CTRL_HOLD: assert property (sel_low_s |=> $stable(CONTROL_REGS))
        else $error("Control registers changed during a frame");
    AST_STAT_HOLD: assert property (sel_low_s |=> (STATUS_REGS & $past(STATUS_REGS)) == $past(STATUS_REGS))
        else $error("Status bit lost during a frame");
    AST_BLOCKED: assert property (blocked_s |=> $stable(CONTROL_REGS))
        else $error("Control registers changed while commands locked out");
    AST_STAT_SET: assert property ((|STATUS_SET) && !SOFT_RESET && !RESTART |=>
        (STATUS_REGS & $past(STATUS_SET)) == $past(STATUS_SET))
        else $error("Hardware status event not recorded");
    AST_MODE_REWRITE: assert property (MODE_CHANGE && !SOFT_RESET && !RESTART |=>
        CONTROL_REGS[7:6] == $past(MODE_ACTUAL))
        else $error("Mode bits do not report mode in effect");
    AST_SLEEP_XCVR: assert property (MODE_CHANGE && MODE_ACTUAL == sbr_pkg::MODE_SLEEP &&
        CONTROL_REGS[25:24] == sbr_pkg::XCVR_ON |=> CONTROL_REGS[25:24] == sbr_pkg::XCVR_WAKE)
        else $error("Transceiver not made wake capable on sleep");
    AST_RESERVED: assert property (((CONTROL_REGS[7:0] & ~sbr_pkg::MASK_MODE_SUPPLY) == 8'h00)
        && ((CONTROL_REGS[39:32] & ~sbr_pkg::MASK_BUS_CTRL_B) == 8'h00))
        else $error("Reserved control bit set");
    AST_OUT_EN: assert property (SELECT_N [*3] |-> !SERIAL_OUT_EN)
        else $error("Serial output driven while deselected");
endmodule // sbr_properties
bind sbr_regbank sbr_properties u_props (
    .CLOCK(CLOCK), .RESET(RESET), .SERIAL_CLK(SERIAL_CLK), .SELECT_N(SELECT_N),
    .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_EN(SERIAL_OUT_EN),
    .SOFT_RESET(SOFT_RESET), .RESTART(RESTART), .SPI_BLOCKED(SPI_BLOCKED),
    .MODE_ACTUAL(MODE_ACTUAL), .MODE_CHANGE(MODE_CHANGE), .STATUS_SET(STATUS_SET),
    .WAKE_PIN_LEVEL(WAKE_PIN_LEVEL), .FAMILY_ID(FAMILY_ID), .CONTROL_REGS(CONTROL_REGS),
    .STATUS_REGS(STATUS_REGS)
);

// >>> tb/sbr_host_model.sv
// Host serial master model that sends frames and captures responses
`timescale 1ns/1ps
module sbr_host_model (
    output logic serial_clk,
    output logic select_n,
    output logic serial_in,
    input  wire logic serial_out
);
    logic [15:0] resp;
    initial begin
        serial_clk = 1'b0;
        select_n   = 1'b1;
        serial_in  = 1'b1;
        resp       = 16'h0000;
    end
    // Clock idles low and only runs inside a frame; 48 ns period
    task automatic frame(input logic [15:0] cmd, input int nclk);
        resp = 16'h0000;
        select_n = 1'b0;
        #24;
        for (int i = 0; i < nclk; i++) begin
            serial_in = cmd[i];
            resp[i] = serial_out;
            #12 serial_clk = 1'b1;
            #24 serial_clk = 1'b0;
            #12;
        end
        #24 select_n = 1'b1;
        serial_in = ~serial_in;
    endtask
endmodule // sbr_host_model

// >>> tb/tb_top.sv
// Self-checking bench for the serial register bank
`timescale 1ns/1ps
module tb_top;
    logic        CLOCK;
    logic        RESET;
    logic        SOFT_RESET;
    logic        RESTART;
    logic        SPI_BLOCKED;
    logic [1:0]  MODE_ACTUAL;
    logic        MODE_CHANGE;
    logic [63:0] STATUS_SET;
    logic [7:0]  WAKE_PIN_LEVEL;
    logic [7:0]  FAMILY_ID;
    wire         SERIAL_CLK;
    wire         SELECT_N;
    wire         SERIAL_IN;
    wire         SERIAL_OUT;
    wire         SERIAL_OUT_EN;
    wire [79:0]  CONTROL_REGS;
    wire [63:0]  STATUS_REGS;
    int          failures;
    int          total_checks;
    int          cycles;
    localparam logic [79:0] RST_V = 80'h0000_0000_0000_0014_0000;
    sbr_regbank u_dut (.CLOCK(CLOCK), .RESET(RESET), .SERIAL_CLK(SERIAL_CLK), .SELECT_N(SELECT_N),
        .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_EN(SERIAL_OUT_EN),
        .SOFT_RESET(SOFT_RESET), .RESTART(RESTART), .SPI_BLOCKED(SPI_BLOCKED),
        .MODE_ACTUAL(MODE_ACTUAL), .MODE_CHANGE(MODE_CHANGE), .STATUS_SET(STATUS_SET),
        .WAKE_PIN_LEVEL(WAKE_PIN_LEVEL), .FAMILY_ID(FAMILY_ID), .CONTROL_REGS(CONTROL_REGS),
        .STATUS_REGS(STATUS_REGS));
    sbr_host_model u_host (.serial_clk(SERIAL_CLK), .select_n(SELECT_N), .serial_in(SERIAL_IN),
        .serial_out(SERIAL_OUT));
    initial CLOCK = 1'b0;
    always #5 CLOCK = ~CLOCK;
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [6:0] addr, input logic acc, input logic [7:0] data);
        u_host.frame({data, acc, addr}, 16);
        repeat (8) @(posedge CLOCK);
        #1;
    endtask
    task automatic pulse(ref logic s);
        @(posedge CLOCK);
        #1 s = 1'b1;
        @(posedge CLOCK);
        #1 s = 1'b0;
        repeat (3) @(posedge CLOCK);
        #1;
    endtask
    function automatic logic [7:0] cr(input int i);
        return CONTROL_REGS[i*8 +: 8];
    endfunction
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("ERROR at %0t: timeout", $time);
            give_verdict();
        end
    end
    initial begin
        {RESET, SOFT_RESET, RESTART, SPI_BLOCKED, MODE_CHANGE} = 5'h10;
        MODE_ACTUAL = sbr_pkg::MODE_NORMAL;
        STATUS_SET = 64'h0;
        WAKE_PIN_LEVEL = 8'h00;
        FAMILY_ID = 8'h5a; // Arbitrary identity byte
        repeat (6) @(posedge CLOCK);
        #1 RESET = 1'b0;
        repeat (4) @(posedge CLOCK);
        chk(CONTROL_REGS, RST_V);
        xfer(sbr_pkg::ADDR_MODE_SUPPLY, 1'b1, 8'h3f);
        chk(cr(0), 8'h1f);
        xfer(sbr_pkg::ADDR_MODE_SUPPLY, 1'b0, 8'haa);
        chk(cr(0), 8'h1f);
        xfer(sbr_pkg::ADDR_SCRATCH, 1'b1, 8'ha5);
        chk(cr(9), 8'ha5);
        chk(u_host.resp[15:8], 8'h1f);
        xfer(sbr_pkg::ADDR_SCRATCH, 1'b0, 8'h00);
        xfer(7'h10, 1'b0, 8'h00);
        chk(u_host.resp[15:8], 8'ha5);
        $display("Control access test done");
        @(posedge CLOCK) #1 STATUS_SET = 64'h1;
        @(posedge CLOCK) #1 STATUS_SET = 64'h0;
        xfer(sbr_pkg::ADDR_SUPPLY_ST, 1'b0, 8'h00);
        chk(u_host.resp[15:8], 8'h00);
        chk(STATUS_REGS[7:0], 8'h01);
        xfer(sbr_pkg::ADDR_SUPPLY_ST, 1'b1, 8'h00);
        chk(u_host.resp, 16'h0101);
        chk(STATUS_REGS[7:0], 8'h00);
        WAKE_PIN_LEVEL = 8'h81;
        xfer(sbr_pkg::ADDR_WAKE_LEVEL, 1'b1, 8'h00);
        xfer(sbr_pkg::ADDR_FAMILY_ID, 1'b0, 8'h00);
        chk(u_host.resp[15:8], 8'h81);
        u_host.frame({8'h11, 1'b1, sbr_pkg::ADDR_SCRATCH}, 15);
        repeat (8) @(posedge CLOCK);
        chk(cr(9), 8'ha5);
        xfer(sbr_pkg::ADDR_SCRATCH, 1'b0, 8'h00);
        chk(u_host.resp[0], 1'b1);
        SPI_BLOCKED = 1'b1;
        xfer(sbr_pkg::ADDR_SCRATCH, 1'b1, 8'h11);
        chk(cr(9), 8'ha5);
        SPI_BLOCKED = 1'b0;
        $display("Status and framing test done");
        xfer(sbr_pkg::ADDR_BUS_CTRL_A, 1'b1, 8'h1b);
        MODE_ACTUAL = sbr_pkg::MODE_SLEEP;
        pulse(MODE_CHANGE);
        chk(cr(3), 8'h09);
        chk(cr(0), 8'h5f);
        MODE_ACTUAL = sbr_pkg::MODE_STOP;
        pulse(MODE_CHANGE);
        xfer(sbr_pkg::ADDR_MODE_SUPPLY, 1'b1, 8'h87);
        chk(cr(0), 8'h9f);
        MODE_ACTUAL = sbr_pkg::MODE_NORMAL;
        pulse(MODE_CHANGE);
        chk(cr(0), 8'h1f);
        xfer(sbr_pkg::ADDR_WATCHDOG_CONTROL, 1'b1, 8'h98);
        chk(cr(2), 8'h98);
        pulse(RESTART);
        chk(cr(2), 8'h9c);
        chk(cr(9), 8'ha5);
        pulse(SOFT_RESET);
        chk(CONTROL_REGS, RST_V);
        $display("Mode and reset test done");
        give_verdict();
    end
endmodule // tb_top
